/* File: src/spm_pkg.sv */
package spm_pkg;

  // global power policy encodings
  localparam logic [1:0] POLICY_DISABLED = 2'h0;
  localparam logic [1:0] POLICY_USER     = 2'h1;
  localparam logic [1:0] POLICY_MIN_SAVE = 2'h2;
  localparam logic [1:0] POLICY_MAX_SAVE = 2'h3;

  // timing base: one minute tick from 100 MHz
  localparam int          CLK_FREQ_HZ      = 100000000;
  localparam int          MINUTE_S         = 60;
  localparam longint      MINUTE_CYCLES    = longint'(CLK_FREQ_HZ) * longint'(MINUTE_S);

  // idle timers count minutes, 6 bits covers the 60 minute top value
  localparam int          MIN_W            = 6;
  localparam logic [5:0]  TIMER_MAX_MIN    = 6'h3c;
  localparam logic [5:0]  TIMER_MIN_MIN    = 6'h01;

  // disk spin-down step table, index 0 means never
  localparam int          SPIN_SEL_W       = 4;

  // throttle: stopped cycles out of a nine-cycle period; default three is one third
  localparam int          THR_W            = 4;
  localparam logic [3:0]  THR_PERIOD       = 4'h9;
  localparam logic [3:0]  THR_STOP_DEFAULT = 4'h3;

  // wake sources: irq lines 1..15 packed into bits 15:1
  localparam int          IRQ_W            = 16;

  // system power state, gray coded along full -> doze -> standby
  typedef enum logic [1:0] {
    SPM_FULL    = 2'b00,
    SPM_DOZE    = 2'b01,
    SPM_STANDBY = 2'b11
  } spm_state_type;

  // minutes for a disk spin-down selection; 0 means disabled
  function automatic logic [5:0] spm_spin_minutes(input logic [3:0] sel);
    case (sel)
      4'h1:    spm_spin_minutes = 6'h01;
      4'h2:    spm_spin_minutes = 6'h02;
      4'h3:    spm_spin_minutes = 6'h03;
      4'h4:    spm_spin_minutes = 6'h04;
      4'h5:    spm_spin_minutes = 6'h05;
      4'h6:    spm_spin_minutes = 6'h06;
      4'h7:    spm_spin_minutes = 6'h08;
      4'h8:    spm_spin_minutes = 6'h0a;
      4'h9:    spm_spin_minutes = 6'h0c;
      4'ha:    spm_spin_minutes = 6'h0f;
      4'hb:    spm_spin_minutes = 6'h10;
      4'hc:    spm_spin_minutes = 6'h14;
      4'hd:    spm_spin_minutes = 6'h1e;
      4'he:    spm_spin_minutes = 6'h28;
      4'hf:    spm_spin_minutes = 6'h3c;
      default: spm_spin_minutes = 6'h00;
    endcase
  endfunction : spm_spin_minutes

endpackage : spm_pkg

/* File: src/spm_sync3.sv */
`timescale 1ns/100ps
// three-stage synchroniser; output changes once stages two and three agree
module spm_sync3 import spm_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  // stage one feeds only stage two
  always_comb begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        out_nxt[i] = s2_r[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule : spm_sync3

/* File: src/spm_throttle.sv */
`timescale 1ns/100ps
// throttle cycle: processor stopped for stop_sel of every period cycles
module spm_throttle import spm_pkg::*; (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // control
  input  wire logic             enable_in,
  input  wire logic             step_in,
  input  wire logic [THR_W-1:0] stop_sel_in,
  // output
  output logic                  cpu_stop_out
);

  logic [THR_W-1:0] phase_r, phase_nxt;
  logic             stop_r, stop_nxt;

  // phase advances on each step pulse; stop in the first stop_sel phases
  always_comb begin
    phase_nxt = phase_r;
    stop_nxt  = 1'b0;
    if (enable_in) begin
      if (step_in) begin
        phase_nxt = (phase_r >= THR_PERIOD - 4'h1) ? 4'h0 : phase_r + 4'h1;
      end
      stop_nxt = (phase_r < stop_sel_in);
    end else begin
      phase_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= 4'h0;
      stop_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      stop_r  <= stop_nxt;
    end
  end

  assign cpu_stop_out = stop_r;

endmodule : spm_throttle

/* File: src/spm_power_manager.sv */
`timescale 1ns/100ps
module spm_power_manager import spm_pkg::*; #(
  parameter longint TICK_CYCLES = MINUTE_CYCLES
) (
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_n_in,
  // policy and timer configuration
  input  wire logic [1:0]            policy_in,
  input  wire logic [MIN_W-1:0]      doze_minutes_in,
  input  wire logic [MIN_W-1:0]      standby_minutes_in,
  input  wire logic [SPIN_SEL_W-1:0] disk_spindown_timeout_in,
  input  wire logic                  throttle_en_in,
  input  wire logic [THR_W-1:0]      throttle_stop_in,
  // wake enables
  input  wire logic                  ring_wake_en_in,
  input  wire logic                  net_wake_en_in,
  input  wire logic                  pme_wake_en_in,
  input  wire logic                  rtc_wake_en_in,
  input  wire logic [IRQ_W-1:0]      irq_wake_en_in,
  input  wire logic                  modem_irq_en_in,
  input  wire logic [3:0]            modem_irq_sel_in,
  // activity and wake pins
  input  wire logic                  ring_ind_in,
  input  wire logic                  net_wake_in,
  input  wire logic                  pme_n_in,
  input  wire logic                  rtc_alarm_in,
  input  wire logic                  resume_btn_in,
  input  wire logic [IRQ_W-1:0]      irq_in,
  input  wire logic                  disk_access_in,
  // power controls
  output logic                       display_blank_out,
  output logic                       display_off_out,
  output logic                       cpu_suspend_out,
  output logic                       cpu_stop_out,
  output logic                       disk_spindown_out,
  output logic                       modem_active_out,
  output logic [1:0]                 power_state_out
);

  // synchronised reset
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // all pins come from outside the clock domain
  localparam int PIN_W = IRQ_W + 7;
  logic [PIN_W-1:0] pins_s;
  spm_sync3 #(.WIDTH(PIN_W)) u_sync (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n),
    .async_in ({irq_in, disk_access_in, resume_btn_in, rtc_alarm_in,
                ~pme_n_in, net_wake_in, ring_ind_in, 1'b0}),
    .sync_out (pins_s)
  );
  logic             ring_s, net_s, pme_s, rtc_s, resume_s, disk_s;
  logic [IRQ_W-1:0] irq_s;
  assign ring_s   = pins_s[1];
  assign net_s    = pins_s[2];
  assign pme_s    = pins_s[3];
  assign rtc_s    = pins_s[4];
  assign resume_s = pins_s[5];
  assign disk_s   = pins_s[6];
  assign irq_s    = pins_s[PIN_W-1:7];

  // effective timer in minutes per policy
  function automatic logic [MIN_W-1:0] pol_min(input logic [1:0] pol,
                                               input logic [MIN_W-1:0] user);
    case (pol)
      POLICY_USER:     pol_min = user;
      POLICY_MIN_SAVE: pol_min = TIMER_MAX_MIN;
      POLICY_MAX_SAVE: pol_min = TIMER_MIN_MIN;
      default:         pol_min = '0;
    endcase
  endfunction : pol_min

  logic             pm_en;
  logic [MIN_W-1:0] doze_lim, stby_lim, spin_lim, spin_user;
  assign pm_en     = (policy_in != POLICY_DISABLED);
  assign spin_user = spm_spin_minutes(disk_spindown_timeout_in);
  assign doze_lim  = pol_min(policy_in, doze_minutes_in);
  assign stby_lim  = pol_min(policy_in, standby_minutes_in);
  // a disabled spin-down stays disabled under the presets
  assign spin_lim  = (spin_user == '0) ? '0 : pol_min(policy_in, spin_user);

  // minute tick divider; the throttle does not use it and steps on every clock
  localparam int TICK_W = 33;
  logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic              tick;
  assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));
  always_comb begin
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
  end

  // modem line monitor
  logic modem_act;
  assign modem_act = modem_irq_en_in && (modem_irq_sel_in != 4'h0)
                     && irq_s[modem_irq_sel_in];

  // system activity restarts the system idle timer
  logic [IRQ_W-1:0] irq_wake_mask;
  logic             wake_evt, activity;
  assign irq_wake_mask = {irq_wake_en_in[IRQ_W-1:1], 1'b0};
  always_comb begin
    wake_evt = 1'b0;
    if (ring_wake_en_in && ring_s) wake_evt = 1'b1;
    if (net_wake_en_in && net_s) wake_evt = 1'b1;
    if (pme_wake_en_in && pme_s) wake_evt = 1'b1;
    if (rtc_wake_en_in && rtc_s) wake_evt = 1'b1;
    if ((irq_s & irq_wake_mask) != '0) wake_evt = 1'b1;
    if (modem_act) wake_evt = 1'b1;
  end
  assign activity = wake_evt || disk_s;

  // system state machine and idle timer
  spm_state_type    state_r, state_nxt;
  logic [MIN_W-1:0] idle_r, idle_nxt;
  always_comb begin
    state_nxt = state_r;
    idle_nxt  = idle_r;
    if (tick && idle_r != TIMER_MAX_MIN) idle_nxt = idle_r + 6'h01;
    case (state_r)
      SPM_FULL: begin
        if (!pm_en) begin
          idle_nxt = '0;
        end else if (activity) begin
          idle_nxt = '0;
        end else if (doze_lim != '0 && idle_r >= doze_lim) begin
          state_nxt = SPM_DOZE;
          idle_nxt  = '0;
        end
      end
      SPM_DOZE: begin
        if (!pm_en || activity) begin
          state_nxt = SPM_FULL;
          idle_nxt  = '0;
        end else if (stby_lim != '0 && idle_r >= stby_lim) begin
          state_nxt = SPM_STANDBY;
          idle_nxt  = '0;
        end
      end
      SPM_STANDBY: begin
        if (resume_s || wake_evt || !pm_en) begin
          state_nxt = SPM_FULL;
          idle_nxt  = '0;
        end
      end
      default: begin
        state_nxt = SPM_FULL;
        idle_nxt  = '0;
      end
    endcase
  end

  // disk idle timer, separate from the system timer
  logic [MIN_W-1:0] disk_idle_r, disk_idle_nxt;
  logic             spin_r, spin_nxt;
  always_comb begin
    disk_idle_nxt = disk_idle_r;
    spin_nxt      = spin_r;
    if (disk_s || !pm_en || spin_lim == '0) begin
      disk_idle_nxt = '0;
      spin_nxt      = 1'b0;
    end else begin
      if (tick && disk_idle_r != TIMER_MAX_MIN) disk_idle_nxt = disk_idle_r + 6'h01;
      if (disk_idle_r >= spin_lim) spin_nxt = 1'b1;
    end
  end

  // outputs decoded from the next state so they land with it
  logic blank_r, dispoff_r, susp_r, modem_r;
  logic blank_nxt, dispoff_nxt, susp_nxt;
  always_comb begin
    blank_nxt   = (state_nxt != SPM_FULL);
    dispoff_nxt = (state_nxt == SPM_STANDBY);
    susp_nxt    = (state_nxt == SPM_STANDBY);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r  <= '0;
      state_r     <= SPM_FULL;
      idle_r      <= '0;
      disk_idle_r <= '0;
      spin_r      <= 1'b0;
      blank_r     <= 1'b0;
      dispoff_r   <= 1'b0;
      susp_r      <= 1'b0;
      modem_r     <= 1'b0;
    end else begin
      tick_cnt_r  <= tick_cnt_nxt;
      state_r     <= state_nxt;
      idle_r      <= idle_nxt;
      disk_idle_r <= disk_idle_nxt;
      spin_r      <= spin_nxt;
      blank_r     <= blank_nxt;
      dispoff_r   <= dispoff_nxt;
      susp_r      <= susp_nxt;
      modem_r     <= modem_act;
    end
  end

  // throttle steps every clock; no throttling while suspended
  spm_throttle u_throttle (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n),
    .enable_in    (pm_en && throttle_en_in && state_r != SPM_STANDBY),
    .step_in      (1'b1),
    .stop_sel_in  (throttle_stop_in),
    .cpu_stop_out (cpu_stop_out)
  );

  assign display_blank_out = blank_r;
  assign display_off_out   = dispoff_r;
  assign cpu_suspend_out   = susp_r;
  assign disk_spindown_out = spin_r;
  assign modem_active_out  = modem_r;
  assign power_state_out   = state_r;

endmodule : spm_power_manager

/* File: testbench/spm_power_manager_chk.sv */
`timescale 1ns/100ps
module spm_power_manager_chk import spm_pkg::*; (
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  // configuration and pins
  input wire logic [1:0] policy_in,
  input wire logic [3:0] disk_spindown_timeout_in,
  input wire logic       throttle_en_in,
  input wire logic       modem_irq_en_in,
  input wire logic       resume_btn_in,
  input wire logic       disk_access_in,
  // outputs watched
  input wire logic       display_blank_out,
  input wire logic       display_off_out,
  input wire logic       cpu_suspend_out,
  input wire logic       cpu_stop_out,
  input wire logic       disk_spindown_out,
  input wire logic       modem_active_out,
  input wire logic [1:0] power_state_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // three quiet cycles leave room for the registered outputs to follow
  pm_off_quiet_a: assert property ((policy_in == POLICY_DISABLED)[*3] |->
    power_state_out == SPM_FULL && !disk_spindown_out && !cpu_stop_out)
    else $error("activity with power management off");
  doze_outputs_a: assert property (power_state_out == SPM_DOZE |->
    display_blank_out && !display_off_out && !cpu_suspend_out)
    else $error("doze outputs wrong");
  standby_outputs_a: assert property (power_state_out == SPM_STANDBY |->
    display_off_out && cpu_suspend_out) else $error("standby outputs wrong");
  full_outputs_a: assert property (power_state_out == SPM_FULL |->
    !display_blank_out && !display_off_out && !cpu_suspend_out)
    else $error("full power outputs wrong");
  state_order_a: assert property ($past(power_state_out) == SPM_FULL |->
    power_state_out != SPM_STANDBY) else $error("standby entered from full");
  resume_exit_a: assert property ($rose(resume_btn_in) && power_state_out == SPM_STANDBY
    |-> ##[1:8] power_state_out == SPM_FULL) else $error("resume ignored");
  disk_wake_a: assert property (disk_access_in[*8] |-> !disk_spindown_out)
    else $error("disk stays down during access");
  throttle_off_a: assert property ((!throttle_en_in)[*3] |-> !cpu_stop_out)
    else $error("stop without throttle");
  modem_off_a: assert property ((!modem_irq_en_in)[*3] |-> !modem_active_out)
    else $error("modem activity while unused");
  spin_never_a: assert property ((policy_in == POLICY_USER &&
    disk_spindown_timeout_in == 4'h0)[*3] |-> !disk_spindown_out)
    else $error("spin-down while disabled");
  // main scenarios reached
  cover property (power_state_out == SPM_DOZE);
  cover property (power_state_out == SPM_STANDBY);
  cover property (disk_spindown_out && cpu_stop_out == 1'b0);
endmodule : spm_power_manager_chk

bind spm_power_manager spm_power_manager_chk u_spm_power_manager_chk (.ref_clk_in,
  .rst_n_in, .policy_in, .disk_spindown_timeout_in, .throttle_en_in, .modem_irq_en_in,
  .resume_btn_in, .disk_access_in, .display_blank_out, .display_off_out, .cpu_suspend_out,
  .cpu_stop_out, .disk_spindown_out, .modem_active_out, .power_state_out);

/* File: testbench/spm_wake_model.sv */
`timescale 1ns/100ps
// wake sources: src 0 ring, 1 net, 2 pme, 3 rtc, 4 irq5, 5 irq4
module spm_wake_model import spm_pkg::*; (
  // control
  input  wire logic [2:0]       src_in,
  input  wire logic             act_in,
  // source pins
  output logic                  ring_out,
  output logic                  net_out,
  output logic                  pme_n_out,
  output logic                  rtc_out,
  output logic      [IRQ_W-1:0] irq_out
);
  // levels held while active; pme idles high as an open-drain pull-up
  always_comb begin
    ring_out   = act_in && src_in == 3'h0;
    net_out    = act_in && src_in == 3'h1;
    pme_n_out  = !(act_in && src_in == 3'h2);
    rtc_out    = act_in && src_in == 3'h3;
    irq_out    = '0;
    irq_out[5] = act_in && src_in == 3'h4;
    irq_out[4] = act_in && src_in == 3'h5;
  end
endmodule : spm_wake_model

/* File: testbench/spm_power_manager_test.sv */
`timescale 1ns/100ps
module spm_power_manager_test import spm_pkg::*; ();
  logic        ref_clk_in, rst_n_in, throttle_en_in, ring_wake_en_in, net_wake_en_in;
  logic        pme_wake_en_in, rtc_wake_en_in, modem_irq_en_in, resume_btn_in;
  logic        disk_access_in, ring_ind_in, net_wake_in, pme_n_in, rtc_alarm_in, act;
  logic        display_blank_out, display_off_out, cpu_suspend_out, cpu_stop_out;
  logic        disk_spindown_out, modem_active_out;
  logic [1:0]  policy_in, power_state_out;
  logic [5:0]  doze_minutes_in, standby_minutes_in;
  logic [3:0]  disk_spindown_timeout_in, throttle_stop_in, modem_irq_sel_in;
  logic [15:0] irq_wake_en_in, irq_in;
  logic [2:0]  src;
  int          errors, compares, tmo, n;

  // ten-cycle minute keeps the presets within a short run
  spm_power_manager #(.TICK_CYCLES(10)) u_spm_power_manager (.ref_clk_in, .rst_n_in,
    .policy_in, .doze_minutes_in, .standby_minutes_in, .disk_spindown_timeout_in,
    .throttle_en_in, .throttle_stop_in, .ring_wake_en_in, .net_wake_en_in, .pme_wake_en_in,
    .rtc_wake_en_in, .irq_wake_en_in, .modem_irq_en_in, .modem_irq_sel_in, .ring_ind_in,
    .net_wake_in, .pme_n_in, .rtc_alarm_in, .resume_btn_in, .irq_in, .disk_access_in,
    .display_blank_out, .display_off_out, .cpu_suspend_out, .cpu_stop_out,
    .disk_spindown_out, .modem_active_out, .power_state_out);
  spm_wake_model u_spm_wake_model (.src_in(src), .act_in(act), .ring_out(ring_ind_in),
    .net_out(net_wake_in), .pme_n_out(pme_n_in), .rtc_out(rtc_alarm_in), .irq_out(irq_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask : cyc

  // bounded wait for a power state
  task automatic wst(input logic [1:0] s, input int lim);
    int i;
    i = 0;
    while (power_state_out !== s && i < lim) begin
      cyc(1);
      i++;
    end
  endtask : wst

  // hang guard well above the expected thousand or so cycles
  always @(posedge ref_clk_in) begin
    tmo++;
    if (tmo == 20000) begin
      errors++;
      results();
    end
  end

  initial begin
    {rst_n_in, throttle_en_in, ring_wake_en_in, net_wake_en_in, pme_wake_en_in} = '0;
    {rtc_wake_en_in, modem_irq_en_in, resume_btn_in, disk_access_in, act} = '0;
    {policy_in, doze_minutes_in, standby_minutes_in, disk_spindown_timeout_in} = '0;
    {modem_irq_sel_in, irq_wake_en_in, src} = '0;
    throttle_stop_in = THR_STOP_DEFAULT;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(10);
    cyc(300);
    chk("state_off", 8'(power_state_out), 8'(SPM_FULL));
    policy_in = POLICY_MIN_SAVE;
    cyc(300);
    chk("state_long", 8'(power_state_out), 8'(SPM_FULL));
    policy_in = POLICY_MAX_SAVE;
    wst(SPM_DOZE, 60);
    chk("state_doze", 8'(power_state_out), 8'(SPM_DOZE));
    chk("doze_out", 8'({display_blank_out, display_off_out, cpu_suspend_out}), 8'h04);
    wst(SPM_STANDBY, 60);
    chk("stby_out", 8'({display_blank_out, display_off_out, cpu_suspend_out}), 8'h07);
    act = 1'b1;
    cyc(20);
    chk("ring_masked", 8'(power_state_out), 8'(SPM_STANDBY));
    resume_btn_in = 1'b1;
    wst(SPM_FULL, 20);
    chk("resume", 8'(power_state_out), 8'(SPM_FULL));
    {resume_btn_in, act} = '0;
    {ring_wake_en_in, net_wake_en_in, pme_wake_en_in, rtc_wake_en_in} = 4'hf;
    irq_wake_en_in = 16'h0020;
    // wake sources 0 to 4 in turn from standby
    for (int k = 0; k < 5; k++) begin
      wst(SPM_STANDBY, 80);
      chk("wake_from", 8'(power_state_out), 8'(SPM_STANDBY));
      src = 3'(k);
      act = 1'b1;
      wst(SPM_FULL, 20);
      chk("wake", 8'(power_state_out), 8'(SPM_FULL));
      act = 1'b0;
      cyc(8);
    end
    // modem enabled on irq4, model drives irq4 (source 5)
    {policy_in, modem_irq_en_in, modem_irq_sel_in, src, act} = {POLICY_USER, 9'h14b};
    cyc(8);
    chk("modem_on", 8'(modem_active_out), 8'h01);
    act = 1'b0;
    cyc(8);
    chk("modem_off", 8'(modem_active_out), 8'h00);
    throttle_en_in = 1'b1;
    cyc(20);
    n = 0;
    repeat (90) begin
      cyc(1);
      if (cpu_stop_out === 1'b1) n++;
    end
    chk("stop_cycles", 8'(n), 8'd30);
    throttle_en_in = 1'b0;
    disk_spindown_timeout_in = 4'h1;
    n = 0;
    while (disk_spindown_out !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("spin_down", 8'(disk_spindown_out), 8'h01);
    disk_access_in = 1'b1;
    cyc(8);
    chk("spin_up", 8'(disk_spindown_out), 8'h00);
    disk_access_in = 1'b0;
    results();
  end
endmodule : spm_power_manager_test
